// >>> design/adc_seq_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 200 MHz bus clock and 8-bit registers in 32-bit words
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
`define OFS_CHANNEL_START 3'h0
`define OFS_TRIGGER_COMPARE 3'h1
`define OFS_CONFIGURATION 3'h2
`define OFS_RESULT_HIGH 3'h3
`define OFS_RESULT_LOW 3'h4
`define OFS_COMPARE_HIGH 3'h5
`define OFS_COMPARE_LOW 3'h6
`define BIT_LOW_POWER 7
`define BIT_DIVIDE_HI 6
`define BIT_DIVIDE_LO 5
`define BIT_LONG_SAMPLE 4
`define BIT_MODE_HI 3
`define BIT_MODE_LO 2
`define BIT_SOURCE_HI 1
`define BIT_SOURCE_LO 0
`define BIT_ACTIVE 7
`define BIT_HW_TRIGGER 6
`define BIT_COMPARE_EN 5
`define BIT_COMPARE_GT 4
`define BIT_IRQ_EN 6
`define BIT_CONTINUOUS 5
`define CHANNEL_OFF 5'h1f
`define RST_CONFIG 8'h00
`define RST_CHANNEL 5'h1f
`define RST_RESULT 12'h000
`define CLK_PERIOD_NS 5
`define ASYNC_STARTUP_NS 5000
`define ASYNC_STARTUP_CYC (`ASYNC_STARTUP_NS / `CLK_PERIOD_NS)
`define SAMPLE_SHORT_HALF 7'd7
`define SAMPLE_LONG_HALF 7'd47
`define CONV_8_HALF 7'd27
`define CONV_10_HALF 7'd33
`define FIRST_EXTRA_HALF 7'd6
`define XFER_FIRST_CYC 3'd5
`endif

// >>> design/adc_seq_pkg.sv
// Types shared by the conversion sequencer
// Assumes nothing beyond the constants header
package adc_seq_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_STARTUP = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONVERT = 3'b011,
      ST_XFER = 3'b100
   } seq_state_type;
   typedef enum logic [1:0] {
      MODE_8 = 2'b00,
      MODE_12 = 2'b01,
      MODE_10 = 2'b10
   } res_mode_type;
   typedef enum logic [1:0] {
      SRC_BUS = 2'b00,
      SRC_BUS_HALF = 2'b01,
      SRC_ALT = 2'b10,
      SRC_ASYNC = 2'b11
   } clk_source_type;
endpackage

// >>> design/adc_conversion_sequencer.sv
// Conversion sequencer of a successive-approximation converter
// Assumes a classic Wishbone master and an analog array on mclk_in
// Operation
// - Sample 3.5 or 23.5 conversion clocks
// - Isolate input, approximate, then transfer result
// - Short first conversion: 20/23 clocks plus 5
// - Long first conversion: 40/43 clocks plus 5
// - Async source adds 5 us startup first
// - Later continuous conversions: 17/20 or 37/40
// - Compare stores result minus compare value
// - Greater select picks >=, else picks <
// - False compare: no flag, no result update
// - Interrupt when complete flag set and enabled
// - Wait mode lets conversions run and start
// - All sources stay usable in wait mode
// - Stop3 without async clock aborts to idle
// - Stop3 with async clock keeps converting
// - Stop2 returns every register to reset
// - Configuration field layout bits 7 to 0
// - Decode divide, resolution and source fields
// - Control2 layout, low four bits zero
// - Active flag reads set while converting
// - Half-read result blocks and discards transfer outside 8-bit mode
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "adc_seq_map.svh"
module adc_conversion_sequencer
   import adc_seq_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [4:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic hw_trigger_in,
   input wire logic alt_clock_in,
   input wire logic async_clock_in,
   input wire logic stop3_mode_in,
   input wire logic stop2_mode_in,
   input wire logic [11:0] analog_result_in,
   output logic sample_out,
   output logic convert_out,
   output logic [4:0] channel_out,
   output logic low_power_out,
   output logic async_clock_enable_out,
   output logic irq_out
);
   function automatic logic [11:0] fit_result(input logic [11:0] r,
                                              input logic [1:0] m);
      logic [12:0] sum;
      sum = 13'h0000;
      if (m == MODE_8) begin
         sum = {1'b0, r} + 13'h0008;
         fit_result = sum[12] ? 12'h0ff : {4'h0, sum[11:4]};
      end else if (m == MODE_10) begin
         sum = {1'b0, r} + 13'h0002;
         fit_result = sum[12] ? 12'h3ff : {2'h0, sum[11:2]};
      end else begin
         fit_result = r;
      end
   endfunction

   function automatic logic [6:0] total_half(input logic lng,
                                             input logic [1:0] m,
                                             input logic frst);
      total_half = (lng ? `SAMPLE_LONG_HALF : `SAMPLE_SHORT_HALF)
         + ((m == MODE_8) ? `CONV_8_HALF : `CONV_10_HALF)
         + (frst ? `FIRST_EXTRA_HALF : 7'd0);
   endfunction

   localparam logic [9:0] STARTUP_CYC = 10'(`ASYNC_STARTUP_CYC);

   seq_state_type state, next_state;
   logic irq_en, continuous, conversion_complete_flag, hw_trig, cmp_en, cmp_gt;
   logic low_power, long_sample, first, hi_read;
   logic [4:0] chan;
   logic [1:0] div_sel, mode, src_sel;
   logic [11:0] result, cmp_val;
   logic [6:0] half_rem, next_half_rem;
   logic [9:0] bus_cnt, next_bus_cnt;
   logic [2:0] div_cnt;
   logic bus_half;
   logic hw_s1, hw_s2, hw_s3;
   logic alt_s1, alt_s2, alt_s3;
   logic as_s1, as_s2, as_s3;
   logic [5:0] conv_ticks;

   // Stop2 acts as a full reset of the block
   wire clear = rst_in | stop2_mode_in;

   wire access = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire wr = access & wb_we_in & wb_sel_in[0];
   wire rd = access & ~wb_we_in;
   wire [2:0] idx = wb_adr_in[4:2];
   wire adr_ok = (wb_adr_in[1:0] == 2'b00);
   wire w_sc1 = wr & adr_ok & (idx == `OFS_CHANNEL_START);
   wire w_sc2 = wr & adr_ok & (idx == `OFS_TRIGGER_COMPARE);
   wire w_cfg = wr & adr_ok & (idx == `OFS_CONFIGURATION);
   wire w_cvh = wr & adr_ok & (idx == `OFS_COMPARE_HIGH);
   wire w_cvl = wr & adr_ok & (idx == `OFS_COMPARE_LOW);
   wire r_rh = rd & adr_ok & (idx == `OFS_RESULT_HIGH);
   wire r_rl = rd & adr_ok & (idx == `OFS_RESULT_LOW);
   wire [7:0] wd = wb_dat_in[7:0];

   // Conversion clock source and divider
   wire hw_edge = hw_s2 & ~hw_s3;
   wire src_tick = (src_sel == SRC_BUS) ? 1'b1 :
                   (src_sel == SRC_BUS_HALF) ? bus_half :
                   (src_sel == SRC_ALT) ? (alt_s2 & ~alt_s3) :
                   (as_s2 & ~as_s3);
   wire [2:0] div_mask = (div_sel == 2'b00) ? 3'd0 :
                         (div_sel == 2'b01) ? 3'd1 :
                         (div_sel == 2'b10) ? 3'd3 : 3'd7;
   wire conversion_clock_tick = src_tick & (div_cnt == div_mask);
   wire async_src = (src_sel == SRC_ASYNC);

   // Compare and blocking
   wire [11:0] fitted = fit_result(analog_result_in, mode);
   wire [11:0] cv_eff = (mode == MODE_8) ? {4'h0, cmp_val[7:0]} :
                        (mode == MODE_10) ? {2'h0, cmp_val[9:0]} :
                        cmp_val;
   wire [11:0] diff = fitted + (~cv_eff + 12'h001);
   wire cmp_true = cmp_gt ? (fitted >= cv_eff)
                          : (fitted < cv_eff);
   wire pass = ~cmp_en | cmp_true;
   wire blocked = hi_read & (mode != MODE_8);
   wire done = (state == ST_XFER) & (bus_cnt == 10'd0);
   wire take = done & pass & ~blocked;
   wire restart = done & (continuous | (blocked & pass));

   // Start and abort conditions
   wire stop_abort = stop3_mode_in & ~async_src;
   wire cfg_write = w_sc2 | w_cfg | w_cvh | w_cvl;
   wire sw_start = w_sc1 & (wd[4:0] != `CHANNEL_OFF)
                   & ~hw_trig & ~stop_abort;
   wire hw_start = hw_trig & hw_edge & (state == ST_IDLE)
                   & (chan != `CHANNEL_OFF) & ~stop_abort
                   & ~cfg_write & ~w_sc1;
   wire abort = cfg_write | w_sc1 | stop_abort;
   wire launch = sw_start | hw_start;
   wire conversion_complete_flag_clr = w_sc1 | r_rl;
   wire active = (state != ST_IDLE);

   wire [7:0] rd_sc1 = {conversion_complete_flag, irq_en, continuous, chan};
   wire [7:0] rd_sc2 = {active, hw_trig, cmp_en, cmp_gt, 4'h0};
   wire [7:0] rd_cfg = {low_power, div_sel, long_sample, mode,
                        src_sel};
   wire [7:0] rd_rh = (mode == MODE_8) ? 8'h00 : {4'h0, result[11:8]};
   wire [7:0] rd_cvh = {4'h0, cmp_val[11:8]};
   wire [7:0] rd_byte = ~adr_ok ? 8'h00 :
                        (idx == `OFS_CHANNEL_START) ? rd_sc1 :
                        (idx == `OFS_TRIGGER_COMPARE) ? rd_sc2 :
                        (idx == `OFS_CONFIGURATION) ? rd_cfg :
                        (idx == `OFS_RESULT_HIGH) ? rd_rh :
                        (idx == `OFS_RESULT_LOW) ? result[7:0] :
                        (idx == `OFS_COMPARE_HIGH) ? rd_cvh :
                        (idx == `OFS_COMPARE_LOW) ? cmp_val[7:0] :
                        8'h00;

   wire [6:0] conv_half = (mode == MODE_8) ? `CONV_8_HALF
                                           : `CONV_10_HALF;
   wire [6:0] half_dec = half_rem - 7'd2;
   // The first conversion's extra ticks belong to the conversion phase
   wire [6:0] sample_end = conv_half
                           + (first ? `FIRST_EXTRA_HALF : 7'd0);

   always_comb begin
      next_state = state;
      next_half_rem = half_rem;
      next_bus_cnt = bus_cnt;
      if (launch) begin
         if (async_src) begin
            next_state = ST_STARTUP;
            next_bus_cnt = STARTUP_CYC - 10'd1;
         end else begin
            next_state = ST_SAMPLE;
            next_half_rem = total_half(long_sample, mode, 1'b1);
         end
      end else if (abort) begin
         next_state = ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            ST_STARTUP: begin
               if (bus_cnt == 10'd0) begin
                  next_state = ST_SAMPLE;
                  next_half_rem = total_half(long_sample, mode, 1'b1);
               end else begin
                  next_bus_cnt = bus_cnt - 10'd1;
               end
            end
            ST_SAMPLE: begin
               if (conversion_clock_tick) begin
                  next_half_rem = half_dec;
                  if (half_dec <= sample_end) begin
                     next_state = ST_CONVERT;
                  end
               end
            end
            ST_CONVERT: begin
               if (conversion_clock_tick) begin
                  next_half_rem = half_dec;
                  if (half_rem <= 7'd2) begin
                     next_state = ST_XFER;
                     next_bus_cnt = first ?
                        {7'd0, `XFER_FIRST_CYC} - 10'd1 : 10'd0;
                  end
               end
            end
            ST_XFER: begin
               if (bus_cnt != 10'd0) begin
                  next_bus_cnt = bus_cnt - 10'd1;
               end else if (restart) begin
                  next_state = ST_SAMPLE;
                  next_half_rem = total_half(long_sample, mode, 1'b0);
               end else begin
                  next_state = ST_IDLE;
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      hw_s1 <= hw_trigger_in;
      hw_s2 <= hw_s1;
      hw_s3 <= hw_s2;
      alt_s1 <= alt_clock_in;
      alt_s2 <= alt_s1;
      alt_s3 <= alt_s2;
      as_s1 <= async_clock_in;
      as_s2 <= as_s1;
      as_s3 <= as_s2;
   end

   always_ff @(posedge mclk_in) begin
      if (clear) begin
         bus_half <= 1'b0;
         div_cnt <= 3'd0;
      end else begin
         bus_half <= ~bus_half;
         if (conversion_clock_tick) begin
            div_cnt <= 3'd0;
         end else if (src_tick) begin
            div_cnt <= div_cnt + 3'd1;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (clear) begin
         state <= ST_IDLE;
         half_rem <= 7'd0;
         bus_cnt <= 10'd0;
         first <= 1'b0;
      end else begin
         state <= next_state;
         half_rem <= next_half_rem;
         bus_cnt <= next_bus_cnt;
         if (launch) begin
            first <= 1'b1;
         end else if (done) begin
            first <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (clear) begin
         irq_en <= 1'b0;
         continuous <= 1'b0;
         chan <= `RST_CHANNEL;
      end else if (w_sc1) begin
         irq_en <= wd[`BIT_IRQ_EN];
         continuous <= wd[`BIT_CONTINUOUS];
         chan <= wd[4:0];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (clear) begin
         hw_trig <= 1'b0;
         cmp_en <= 1'b0;
         cmp_gt <= 1'b0;
      end else if (w_sc2) begin
         hw_trig <= wd[`BIT_HW_TRIGGER];
         cmp_en <= wd[`BIT_COMPARE_EN];
         cmp_gt <= wd[`BIT_COMPARE_GT];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (clear) begin
         {low_power, div_sel, long_sample, mode, src_sel} <= `RST_CONFIG;
      end else if (w_cfg) begin
         low_power <= wd[`BIT_LOW_POWER];
         div_sel <= wd[`BIT_DIVIDE_HI:`BIT_DIVIDE_LO];
         long_sample <= wd[`BIT_LONG_SAMPLE];
         mode <= wd[`BIT_MODE_HI:`BIT_MODE_LO];
         src_sel <= wd[`BIT_SOURCE_HI:`BIT_SOURCE_LO];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (clear) begin
         cmp_val <= 12'h000;
      end else if (w_cvh) begin
         cmp_val[11:8] <= wd[3:0];
      end else if (w_cvl) begin
         cmp_val[7:0] <= wd;
      end
   end

   // Result survives aborts and stop3; set of the flag beats its clear
   always_ff @(posedge mclk_in) begin
      if (clear) begin
         result <= `RST_RESULT;
         conversion_complete_flag <= 1'b0;
         hi_read <= 1'b0;
      end else begin
         if (take) begin
            result <= cmp_en ? diff : fitted;
         end
         conversion_complete_flag <= take | (conversion_complete_flag & ~conversion_complete_flag_clr);
         if (r_rh) begin
            hi_read <= 1'b1;
         end else if (r_rl) begin
            hi_read <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (clear) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= access;
         wb_dat_out <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (clear) begin
         sample_out <= 1'b0;
         convert_out <= 1'b0;
         channel_out <= `RST_CHANNEL;
         low_power_out <= 1'b0;
         async_clock_enable_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         sample_out <= (next_state == ST_SAMPLE);
         convert_out <= (next_state == ST_CONVERT);
         channel_out <= chan;
         low_power_out <= low_power;
         async_clock_enable_out <= async_src
                                   & (next_state != ST_IDLE);
         irq_out <= conversion_complete_flag & irq_en;
      end
   end

   // Conversion-clock ticks spent sampling and converting
   always_ff @(posedge mclk_in) begin
      if (clear || state == ST_IDLE || state == ST_STARTUP
          || state == ST_XFER) begin
         conv_ticks <= 6'd0;
      end else if (conversion_clock_tick) begin
         conv_ticks <= conv_ticks + 6'd1;
      end
   end

   default clocking @(posedge mclk_in); endclocking
   default disable iff (clear);

   a_irq_follows: assert property (conversion_complete_flag && irq_en |=> irq_out)
      else $error("interrupt missing after complete flag");
   a_active_flag: assert property (rd && adr_ok
      && idx == `OFS_TRIGGER_COMPARE && (sample_out || convert_out)
      |=> wb_dat_out[`BIT_ACTIVE])
      else $error("active flag clear during conversion");
   a_false_keep: assert property (done && cmp_en && !cmp_true
      |=> $stable(result) && !$rose(conversion_complete_flag))
      else $error("false compare changed result or flag");
   a_block_keep: assert property (done && blocked
      |=> $stable(result) && !$rose(conversion_complete_flag))
      else $error("blocked transfer changed result");
   a_diff_store: assert property (take && cmp_en
      |=> result == $past(diff))
      else $error("compare difference not stored");
   a_stop3_idle: assert property (stop3_mode_in && !async_src
      |=> state == ST_IDLE)
      else $error("stop3 did not abort conversion");
   a_conv_long: assert property (state == ST_XFER
      |-> conv_ticks <= 6'd43)
      else $error("conversion exceeded long bound");
   a_conv_short: assert property (state == ST_XFER && !long_sample
      && mode == MODE_8 |-> conv_ticks <= 6'd20)
      else $error("short 8-bit conversion too long");
   a_first_xfer: assert property ($rose(state == ST_XFER) && first
      |-> (state == ST_XFER) [*5])
      else $error("first transfer not five bus cycles");
   a_sar_isolated: assert property ($fell(sample_out)
      && !$past(abort) && !$past(clear) |-> convert_out)
      else $error("sampling ended without approximation");
   a_stop2_clear: assert property (disable iff (rst_in) stop2_mode_in
      |=> state == ST_IDLE && result == 12'h000)
      else $error("stop2 did not clear the block");
endmodule

// >>> verification/analog_array_model.sv
// Behavioural model of the sampling array and the selected input channel
// Assumes the sequencer's sample strobe on the same bus clock
`timescale 1ns/1ps
module analog_array_model (
   input wire logic mclk_in,
   input wire logic sample_in,
   input wire logic [11:0] level_in,
   output logic [11:0] result_out
);
   logic [11:0] held = 12'h000;
   logic sample_prev = 1'b0;

   // While the capacitor charges the output means nothing, so it toggles
   always @(posedge mclk_in) begin
      sample_prev <= sample_in;
      if (sample_prev && !sample_in) begin
         held <= level_in;
      end else if (sample_in) begin
         held <= ~held;
      end
   end
   assign result_out = held;
endmodule

// >>> verification/adc_conversion_sequencer_tb.sv
// Self-checking bench for the conversion sequencer
// Assumes the analog array model and a 200 MHz bus clock
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [3:0] sel = 4'h0;
   logic trig = 1'b0;
   logic async_clk = 1'b0;
   logic stop3 = 1'b0;
   logic stop2 = 1'b0;
   logic [11:0] level = 12'h5a4;
   logic [11:0] analog;
   logic [31:0] rdat;
   logic ack, sample, convert, low_power, async_en, irq;
   logic [4:0] channel;
   logic [7:0] q, rh;
   int fails = 0;
   int checked = 0;
   int total, samp, lng, m;
   logic [1:0] modes [3] = '{2'b00, 2'b10, 2'b01};
   int ticks [3] = '{20, 23, 23};
   logic [11:0] fitted [3] = '{12'h05a, 12'h169, 12'h5a4};
   logic [11:0] cmpv [4] = '{12'h500, 12'h600, 12'h600, 12'h500};
   logic gt [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   logic hit [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   logic [11:0] stored [4] = '{12'h0a4, 12'h0a4, 12'hfa4, 12'hfa4};

   always #2.5 mclk_in = ~mclk_in;
   always #18.5 async_clk = ~async_clk;

   adc_conversion_sequencer u_dut (
      .mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
      .wb_dat_out(rdat), .wb_ack_out(ack), .hw_trigger_in(trig),
      .alt_clock_in(1'b0), .async_clock_in(async_clk),
      .stop3_mode_in(stop3), .stop2_mode_in(stop2),
      .analog_result_in(analog), .sample_out(sample), .convert_out(convert),
      .channel_out(channel), .low_power_out(low_power),
      .async_clock_enable_out(async_en), .irq_out(irq)
   );

   analog_array_model u_array (
      .mclk_in(mclk_in), .sample_in(sample), .level_in(level),
      .result_out(analog)
   );

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [11:0] exp,
                        input logic [11:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic check_range(input string name, input int lo, input int hi,
                              input int got);
      checked++;
      if (got < lo || got > hi) begin
         fails++;
         $display("unexpected %s: expected %0d..%0d, seen %0d", name, lo,
                  hi, got);
      end
   endtask

   // Classic single cycle, held until ack is sampled high
   task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] r);
      int n;
      n = 0;
      @(posedge mclk_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {24'h00_0000, d};
      do begin
         @(posedge mclk_in);
         n++;
      end while (ack !== 1'b1 && n < 50);
      check("bus ack", 12'h001, {11'h000, ack});
      r = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] r;
      bus(a, 1'b1, d, r);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] r;
      bus(a, 1'b0, 8'h00, r);
      check($sformatf("register %h", a), {4'h0, exp}, {4'h0, r});
   endtask

   // High byte first so that the pair cannot be torn by a new transfer
   task automatic result(input logic [11:0] exp);
      bus(5'h0c, 1'b0, 8'h00, rh);
      bus(5'h10, 1'b0, 8'h00, q);
      check("result", exp, {rh[3:0], q});
   endtask

   task automatic run_conv(input int limit);
      total = 0;
      samp = 0;
      while (irq !== 1'b1 && total < limit) begin
         @(posedge mclk_in);
         total++;
         if (sample === 1'b1) samp++;
      end
   endtask

   task automatic wait_sample(input logic v);
      int n;
      n = 0;
      while (sample !== v && n < 200) begin
         @(posedge mclk_in);
         n++;
         total++;
      end
   endtask

   initial begin
      repeat (4) @(posedge mclk_in);
      rst_in <= 1'b0;
      rd(5'h08, 8'h00);
      rd(5'h04, 8'h00);
      rd(5'h00, 8'h1f);
      rd(5'h1c, 8'h00);
      result(12'h000);
      wr(5'h08, 8'h98);
      rd(5'h08, 8'h98);
      check("low power", 12'h001, {11'h000, low_power});
      wr(5'h04, 8'h30);
      rd(5'h04, 8'h30);
      wr(5'h04, 8'h00);
      for (int i = 0; i < 6; i++) begin
         lng = i / 3;
         m = i % 3;
         wr(5'h08, {3'b000, lng[0], modes[m], 2'b00});
         wr(5'h00, 8'h41);
         run_conv(200);
         check_range("cycles", ticks[m] + lng * 20,
                     ticks[m] + lng * 20 + 8, total);
         check_range("sample", 3 + lng * 20, 4 + lng * 20, samp);
         result(fitted[m]);
         @(posedge mclk_in);
         check("irq cleared", 12'h000, {11'h000, irq});
      end
      wr(5'h00, 8'h01);
      run_conv(80);
      check("irq masked", 12'h000, {11'h000, irq});
      rd(5'h00, 8'h81);
      result(12'h5a4);
      wr(5'h08, 8'h04);
      wr(5'h00, 8'h61);
      run_conv(200);
      wait_sample(1'b1);
      total = 0;
      wait_sample(1'b0);
      wait_sample(1'b1);
      check_range("continuous period", 4, 22, total);
      wr(5'h00, 8'h1f);
      result(12'h5a4);
      for (int i = 0; i < 4; i++) begin
         wr(5'h14, {4'h0, cmpv[i][11:8]});
         wr(5'h18, cmpv[i][7:0]);
         wr(5'h04, {2'b00, 1'b1, gt[i], 4'h0});
         wr(5'h00, 8'h41);
         run_conv(80);
         check("compare", {11'h000, hit[i]}, {11'h000, irq});
         result(stored[i]);
      end
      wr(5'h04, 8'h00);
      wr(5'h00, 8'h41);
      rd(5'h04, 8'h80);
      stop3 <= 1'b1;
      repeat (3) @(posedge mclk_in);
      check("busy in stop3", 12'h000, {10'h000, sample, convert});
      stop3 <= 1'b0;
      run_conv(80);
      check("no restart", 12'h000, {11'h000, irq});
      rd(5'h04, 8'h00);
      result(12'hfa4);
      wr(5'h08, 8'h07);
      wr(5'h00, 8'h41);
      stop3 <= 1'b1;
      @(posedge mclk_in);
      check("async on", 12'h001, {11'h000, async_en});
      run_conv(1500);
      check_range("async cycles", 1000, 1210, total + 1);
      stop3 <= 1'b0;
      result(12'h5a4);
      wr(5'h08, 8'h04);
      wr(5'h04, 8'h40);
      wr(5'h00, 8'h41);
      run_conv(60);
      check("no soft start", 12'h000, {11'h000, irq});
      trig <= 1'b1;
      run_conv(60);
      check_range("triggered", 1, 36, total);
      trig <= 1'b0;
      wr(5'h04, 8'h00);
      result(12'h5a4);
      // Bus clock halved and divided by two: one tick every four cycles
      wr(5'h08, 8'h21);
      wr(5'h00, 8'h41);
      run_conv(200);
      check_range("divided cycles", 80, 88, total);
      check_range("divided sample", 12, 16, samp);
      result(12'h05a);
      // Half-read result blocks transfers until the low byte is read
      wr(5'h08, 8'h04);
      bus(5'h0c, 1'b0, 8'h00, rh);
      wr(5'h00, 8'h41);
      run_conv(80);
      check("blocked", 12'h000, {11'h000, irq});
      bus(5'h10, 1'b0, 8'h00, q);
      run_conv(80);
      check("unblocked", 12'h001, {11'h000, irq});
      result(12'h5a4);
      wr(5'h08, 8'h98);
      stop2 <= 1'b1;
      repeat (2) @(posedge mclk_in);
      stop2 <= 1'b0;
      rd(5'h08, 8'h00);
      check("low power off", 12'h000, {11'h000, low_power});
      check("channel off", 12'h01f, {7'h00, channel});
      result(12'h000);
      conclude();
   end

   initial begin
      repeat (20000) @(posedge mclk_in);
      fails++;
      conclude();
   end
endmodule
